// ===== pkg/eac_pkg.sv
// shared constants and types for the effective address calculator
`default_nettype none
package eac_pkg;
    localparam int unsigned EAC_DATA_W  = 32;
    localparam int unsigned EAC_NREG    = 16;
    localparam int unsigned EAC_RSEL_W  = 4;
    localparam logic        EAC_BANK_D  = 1'b0;
    localparam logic        EAC_BANK_A  = 1'b1;
    localparam logic [31:0] EAC_RST_W   = 32'h0000_0000;
    localparam logic [31:0] EAC_STEP_B  = 32'h0000_0001;
    localparam logic [31:0] EAC_STEP_W  = 32'h0000_0002;
    localparam logic [31:0] EAC_STEP_L  = 32'h0000_0004;
    localparam logic [31:0] EAC_ONES    = 32'hffff_ffff;

    typedef enum logic [3:0] {
        EAC_M_DREG     = 4'h0,
        EAC_M_AREG     = 4'h1,
        EAC_M_AIND     = 4'h2,
        EAC_M_POSTINC  = 4'h3,
        EAC_M_PREDEC   = 4'h4,
        EAC_M_DISP16   = 4'h5,
        EAC_M_IDX8     = 4'h6,
        EAC_M_IDXBD    = 4'h7,
        EAC_M_MEM_POST = 4'h8,
        EAC_M_MEM_PRE  = 4'h9,
        EAC_M_ABS_S    = 4'ha,
        EAC_M_ABS_L    = 4'hb,
        EAC_M_IMM      = 4'hc
    } eac_mode_t;

    typedef enum logic [1:0] {
        EAC_SZ_BYTE = 2'h0,
        EAC_SZ_WORD = 2'h1,
        EAC_SZ_LONG = 2'h2,
        EAC_SZ_QUAD = 2'h3
    } eac_size_t;

    typedef enum logic [1:0] {
        EAC_DT_INT     = 2'h0,
        EAC_DT_BITF    = 2'h1,
        EAC_DT_BCD_PK  = 2'h2,
        EAC_DT_BCD_UNP = 2'h3
    } eac_dtype_t;

    typedef enum logic [1:0] {
        EAC_ST_IDLE  = 2'h0,
        EAC_ST_READ  = 2'h1,
        EAC_ST_CALC  = 2'h2,
        EAC_ST_FETCH = 2'h3
    } eac_state_t;

    typedef struct packed {
        eac_state_t  state;
        eac_mode_t   mode;
        logic        pc_rel;
        eac_size_t   size;
        eac_dtype_t  dtype;
        logic [1:0]  scale;
        logic        idx_long;
        logic [3:0]  ra;
        logic [3:0]  rb;
        logic [31:0] pc;
        logic [31:0] disp;
        logic [31:0] od;
        logic [31:0] imm;
        logic [31:0] base;
        logic [31:0] idx;
        logic [31:0] ea;
        logic [31:0] fetch_addr;
        logic [31:0] bf_mask;
        logic [63:0] operand;
        logic        is_operand;
        logic        done;
        logic        fetch_req;
    } eac_core_t;
endpackage
`default_nettype wire

// ===== rtl/eac_regfile.sv
// sixteen-word register file: two registered read ports, one write port
`default_nettype none
module eac_regfile (
    input  wire logic        ref_clk,  // core clock
    input  wire logic        reset_n,  // async reset, active low
    input  wire logic        ce,       // clock enable
    input  wire logic [3:0]  ra,       // read port a select
    input  wire logic [3:0]  rb,       // read port b select
    input  wire logic        we,       // write enable
    input  wire logic [3:0]  wsel,     // write select
    input  wire logic [31:0] wdata,    // write data
    output var  logic [31:0] rd_a,     // read data a, one cycle late
    output var  logic [31:0] rd_b      // read data b, one cycle late
);
    logic [31:0] mem_reg [eac_pkg::EAC_NREG];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_a <= eac_pkg::EAC_RST_W;
            rd_b <= eac_pkg::EAC_RST_W;
        end else if (ce) begin
            rd_a <= mem_reg[ra];
            rd_b <= mem_reg[rb];
        end
    end

    for (genvar i = 0; i < eac_pkg::EAC_NREG; i++) begin : g_word
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                mem_reg[i] <= eac_pkg::EAC_RST_W;
            end else if (ce && we && wsel == 4'(i)) begin
                mem_reg[i] <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/eac_core.sv
// effective address and operand calculator with indirect long-word fetch
// Function
// - eight data and eight address registers, chosen by 3-bit numbers, feed the modes.
// - 8- and 16-bit short displacements are sign-extended and added.
// - index from any register, word sign-extended or long, scaled by 1/2/4/8.
// - base displacement is 16 or 32 bits, two's complement, added in.
// - outer displacement of 16 or 32 bits is added after the indirect fetch.
// - memory indirect reads a long word and uses it as the new base.
// - post-indexed: fetch at base plus bd; index and od added afterwards.
// - pre-indexed: index added before fetch; od added afterwards.
// - PC-relative variants use the program counter as base.
// - address register postincrement after and predecrement before the access.
// - immediates are 8, 16 or 32 bits wide by operation size.
// - absolute addresses come in short and long forms.
// - bit field operands are 1 to 32 consecutive bits.
// - decimal operands handled packed and unpacked.
// - integers as byte, word, long and quad.
`default_nettype none
module eac_core (
    input  wire logic        ref_clk,             // core clock, 20 MHz
    input  wire logic        reset_n,             // async reset, active low
    input  wire logic        ce,                  // clock enable, freezes all state
    input  wire logic        start,               // request strobe, taken when idle
    input  wire logic [3:0]  mode,                // addressing mode code
    input  wire logic        pc_rel,              // use pc as base
    input  wire logic [1:0]  op_size,             // byte, word, long, quad
    input  wire logic [1:0]  data_type,           // integer, bit field, bcd packed/unpacked
    input  wire logic [2:0]  data_reg_sel,        // data register number
    input  wire logic [2:0]  addr_reg_sel,        // address register number
    input  wire logic [2:0]  index_reg_sel,       // index register number
    input  wire logic        index_is_addr,       // index taken from address bank
    input  wire logic        index_long,          // index used as long word
    input  wire logic [1:0]  index_scale,         // scale as shift count 0..3
    input  wire logic [7:0]  short_disp_byte,     // 8-bit displacement
    input  wire logic [15:0] short_disp_word,     // 16-bit displacement
    input  wire logic [31:0] base_displacement,   // base displacement
    input  wire logic        bd_present,          // base displacement present
    input  wire logic        bd_long,             // base displacement is 32-bit
    input  wire logic [31:0] outer_displacement,  // outer displacement
    input  wire logic        od_present,          // outer displacement present
    input  wire logic        od_long,             // outer displacement is 32-bit
    input  wire logic [31:0] abs_addr,            // absolute address extension
    input  wire logic [31:0] imm_data,            // immediate extension
    input  wire logic [4:0]  bf_width,            // bit field width, 0 means 32
    input  wire logic [31:0] pc,                  // program counter
    input  wire logic        ext_we,              // register write from core, idle only
    input  wire logic [3:0]  ext_wsel,            // register write select
    input  wire logic [31:0] ext_wdata,           // register write data
    input  wire logic [31:0] fetch_data,          // fetched long word
    input  wire logic        fetch_ack,           // fetch complete
    output var  logic        fetch_req,           // long-word fetch request
    output var  logic [31:0] fetch_addr,          // fetch address
    output var  logic        done,                // result valid pulse
    output var  logic        busy,                // request in progress
    output var  logic        is_operand,          // result is operand, not address
    output var  logic [31:0] ea_out,              // effective address
    output var  logic [63:0] operand_out,         // operand value
    output var  logic [31:0] bf_mask              // bit field mask
);
    eac_pkg::eac_core_t s_reg;
    eac_pkg::eac_core_t s_next;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic        own_we;
    logic [31:0] own_wdata;
    logic [31:0] idx_probe;

    function automatic logic [31:0] sext8(input logic [7:0] v);
        return {{24{v[7]}}, v};
    endfunction

    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] size_step(input eac_pkg::eac_size_t sz);
        case (sz)
            eac_pkg::EAC_SZ_BYTE: return eac_pkg::EAC_STEP_B;
            eac_pkg::EAC_SZ_WORD: return eac_pkg::EAC_STEP_W;
            default:              return eac_pkg::EAC_STEP_L;
        endcase
    endfunction

    function automatic logic [31:0] size_mask(input logic [31:0] v, input eac_pkg::eac_size_t sz);
        case (sz)
            eac_pkg::EAC_SZ_BYTE: return {24'h0, v[7:0]};
            eac_pkg::EAC_SZ_WORD: return {16'h0, v[15:0]};
            default:              return v;
        endcase
    endfunction

    eac_regfile u_regfile (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .ce      (ce),
        .ra      (s_reg.ra),
        .rb      (s_reg.rb),
        .we      (own_we || (ext_we && s_reg.state == eac_pkg::EAC_ST_IDLE)),
        .wsel    (own_we ? s_reg.ra : ext_wsel),
        .wdata   (own_we ? own_wdata : ext_wdata),
        .rd_a    (rd_a),
        .rd_b    (rd_b)
    );

    always_comb begin
        logic [31:0] base;
        logic [31:0] idx;
        logic [31:0] step;
        logic [63:0] val;
        eac_pkg::eac_mode_t m;
        base      = s_reg.pc_rel ? s_reg.pc : rd_a;
        idx       = 32'((s_reg.idx_long ? rd_b : sext16(rd_b[15:0])) << s_reg.scale);
        step      = size_step(s_reg.size);
        val       = 64'h0;
        m         = eac_pkg::eac_mode_t'(mode);
        s_next    = s_reg;
        s_next.done = 1'b0;
        own_we    = 1'b0;
        own_wdata = rd_a;
        case (s_reg.state)
            eac_pkg::EAC_ST_IDLE: begin
                if (start) begin
                    s_next.state    = eac_pkg::EAC_ST_READ;
                    s_next.mode     = m;
                    s_next.pc_rel   = pc_rel;
                    s_next.size     = eac_pkg::eac_size_t'(op_size);
                    s_next.dtype    = eac_pkg::eac_dtype_t'(data_type);
                    s_next.scale    = index_scale;
                    s_next.idx_long = index_long;
                    s_next.pc       = pc;
                    s_next.ra       = (m == eac_pkg::EAC_M_DREG) ? {eac_pkg::EAC_BANK_D, data_reg_sel}
                                                               : {eac_pkg::EAC_BANK_A, addr_reg_sel};
                    // a quad data register operand takes its high half from the next data register; address register mode reads rb as the index register
                    s_next.rb       = (m == eac_pkg::EAC_M_DREG) ? {eac_pkg::EAC_BANK_D, 3'(data_reg_sel + 3'h1)}
                                                               : {index_is_addr, index_reg_sel};
                    s_next.od       = !od_present ? 32'h0 :
                                      od_long ? outer_displacement : sext16(outer_displacement[15:0]);
                    if (m == eac_pkg::EAC_M_DISP16) begin
                        s_next.disp = sext16(short_disp_word);
                    end else if (m == eac_pkg::EAC_M_IDX8) begin
                        s_next.disp = sext8(short_disp_byte);
                    end else if (m == eac_pkg::EAC_M_ABS_S) begin
                        s_next.disp = sext16(abs_addr[15:0]);
                    end else if (m == eac_pkg::EAC_M_ABS_L) begin
                        s_next.disp = abs_addr;
                    end else begin
                        s_next.disp = !bd_present ? 32'h0 :
                                      bd_long ? base_displacement : sext16(base_displacement[15:0]);
                    end
                    s_next.imm      = size_mask(imm_data, eac_pkg::eac_size_t'(op_size));
                    s_next.bf_mask  = (bf_width == 5'h0) ? eac_pkg::EAC_ONES
                                                         : 32'((32'h1 << bf_width) - 32'h1);
                end
            end
            eac_pkg::EAC_ST_READ: begin
                s_next.state = eac_pkg::EAC_ST_CALC;
            end
            eac_pkg::EAC_ST_CALC: begin
                s_next.base       = base;
                s_next.idx        = idx;
                s_next.state      = eac_pkg::EAC_ST_IDLE;
                s_next.done       = 1'b1;
                s_next.is_operand = 1'b0;
                s_next.ea         = 32'h0;
                // all sums below are 32 bits wide, so carries out of bit 31 drop
                case (s_reg.mode)
                    eac_pkg::EAC_M_DREG, eac_pkg::EAC_M_AREG: begin
                        s_next.is_operand = 1'b1;
                        case (s_reg.dtype)
                            eac_pkg::EAC_DT_BCD_PK:  val = {56'h0, rd_a[11:8], rd_a[3:0]};
                            eac_pkg::EAC_DT_BCD_UNP: val = {48'h0, 4'h0, rd_a[7:4], 4'h0, rd_a[3:0]};
                            eac_pkg::EAC_DT_BITF:    val = {32'h0, rd_a & s_reg.bf_mask};
                            default: begin
                                val = (s_reg.size == eac_pkg::EAC_SZ_QUAD) ? {rd_b, rd_a}
                                                                           : {32'h0, size_mask(rd_a, s_reg.size)};
                            end
                        endcase
                        s_next.operand = val;
                    end
                    eac_pkg::EAC_M_AIND: begin
                        s_next.ea = rd_a;
                    end
                    eac_pkg::EAC_M_POSTINC: begin
                        s_next.ea = rd_a;
                        own_we    = ce;
                        own_wdata = rd_a + step;
                    end
                    eac_pkg::EAC_M_PREDEC: begin
                        s_next.ea = rd_a - step;
                        own_we    = ce;
                        own_wdata = rd_a - step;
                    end
                    eac_pkg::EAC_M_DISP16: begin
                        s_next.ea = base + s_reg.disp;
                    end
                    eac_pkg::EAC_M_IDX8, eac_pkg::EAC_M_IDXBD: begin
                        s_next.ea = base + s_reg.disp + idx;
                    end
                    eac_pkg::EAC_M_MEM_POST: begin
                        s_next.fetch_addr = base + s_reg.disp;
                        s_next.fetch_req  = 1'b1;
                        s_next.state      = eac_pkg::EAC_ST_FETCH;
                        s_next.done       = 1'b0;
                    end
                    eac_pkg::EAC_M_MEM_PRE: begin
                        s_next.fetch_addr = base + s_reg.disp + idx;
                        s_next.idx        = 32'h0;
                        s_next.fetch_req  = 1'b1;
                        s_next.state      = eac_pkg::EAC_ST_FETCH;
                        s_next.done       = 1'b0;
                    end
                    eac_pkg::EAC_M_ABS_S, eac_pkg::EAC_M_ABS_L: begin
                        s_next.ea = s_reg.disp;
                    end
                    default: begin
                        s_next.is_operand = 1'b1;
                        s_next.operand    = {32'h0, s_reg.imm};
                    end
                endcase
            end
            eac_pkg::EAC_ST_FETCH: begin
                if (fetch_ack) begin
                    // the fetched word replaces the base; od only joins afterwards
                    s_next.ea        = fetch_data + s_reg.idx + s_reg.od;
                    s_next.fetch_req = 1'b0;
                    s_next.done      = 1'b1;
                    s_next.state     = eac_pkg::EAC_ST_IDLE;
                end
            end
            default: begin
                s_next.state = eac_pkg::EAC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else if (ce) begin
            busy <= s_next.state != eac_pkg::EAC_ST_IDLE;
        end
    end

    assign fetch_req   = s_reg.fetch_req;
    assign fetch_addr  = s_reg.fetch_addr;
    assign done        = s_reg.done;
    assign is_operand  = s_reg.is_operand;
    assign ea_out      = s_reg.ea;
    assign operand_out = s_reg.operand;
    assign bf_mask     = s_reg.bf_mask;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_fetch_issue;
        ce && s_reg.state == eac_pkg::EAC_ST_CALC &&
        (s_reg.mode == eac_pkg::EAC_M_MEM_POST || s_reg.mode == eac_pkg::EAC_M_MEM_PRE);
    endsequence

    sequence s_fetch_take;
        ce && fetch_req && fetch_ack;
    endsequence

    a_disp_short_ext: assert property (done && s_reg.mode == eac_pkg::EAC_M_IDX8 |->
        s_reg.disp[31:8] == {24{s_reg.disp[7]}} && ea_out == 32'(s_reg.base + s_reg.disp + s_reg.idx))
        else $error("short displacement sum wrong");
    a_index_scaled: assert property (ce && s_reg.state == eac_pkg::EAC_ST_CALC &&
        s_reg.mode == eac_pkg::EAC_M_IDXBD && s_reg.idx_long && !s_reg.pc_rel |=>
        ea_out == 32'($past(rd_a) + s_reg.disp + 32'($past(rd_b) << s_reg.scale)))
        else $error("scaled index sum wrong");
    a_pre_index_fetch: assert property (s_fetch_issue ##1 s_reg.mode == eac_pkg::EAC_M_MEM_PRE |->
        fetch_req && fetch_addr == 32'(s_reg.base + s_reg.disp + $past(idx_probe)))
        else $error("pre-indexed fetch address wrong");
    a_post_index_fetch: assert property (s_fetch_issue ##1 s_reg.mode == eac_pkg::EAC_M_MEM_POST |->
        fetch_req && fetch_addr == 32'(s_reg.base + s_reg.disp))
        else $error("post-indexed fetch address wrong");
    a_fetch_hold: assert property (fetch_req && !(ce && fetch_ack) |=> fetch_req && $stable(fetch_addr))
        else $error("fetch request dropped early");
    a_outer_after: assert property (s_fetch_take |=>
        done && ea_out == 32'($past(fetch_data) + s_reg.idx + s_reg.od))
        else $error("outer displacement sum wrong");
    a_predec_step: assert property (done && s_reg.mode == eac_pkg::EAC_M_PREDEC |->
        ea_out == 32'($past(rd_a) - size_step(s_reg.size)))
        else $error("predecrement step wrong");
    a_abs_short: assert property (done && s_reg.mode == eac_pkg::EAC_M_ABS_S |->
        ea_out[31:16] == {16{ea_out[15]}})
        else $error("short absolute not sign-extended");
    a_imm_width: assert property (done && s_reg.mode == eac_pkg::EAC_M_IMM &&
        s_reg.size == eac_pkg::EAC_SZ_BYTE |-> is_operand && operand_out[63:8] == 56'h0)
        else $error("byte immediate not masked");
    a_done_pulse: assert property (ce && done |=> !done)
        else $error("done held beyond one cycle");

    // written apart from the datapath form so the fetch check is not a copy of it
    assign idx_probe = s_reg.idx_long ? (rd_b << s_reg.scale) : ({{16{rd_b[15]}}, rd_b[15:0]} << s_reg.scale);
endmodule
`default_nettype wire

// ===== testbench/eac_fetch_mem.sv
// bus controller stand-in that answers long-word fetches, promptly or with wait states
`default_nettype none
module eac_fetch_mem (
    input  wire logic        ref_clk,     // core clock
    input  wire logic        reset_n,     // async reset, active low
    input  wire logic        slow,        // insert two wait states
    input  wire logic        fetch_req,   // fetch request
    input  wire logic [31:0] fetch_addr,  // fetch address
    output var  logic [31:0] fetch_data,  // fetched long word
    output var  logic        fetch_ack    // fetch complete
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_reg;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg <= 2'h0;
            fetch_ack <= 1'b0;
            fetch_data <= 32'h0;
        end else if (fetch_req && !fetch_ack && wait_reg == (slow ? 2'h2 : 2'h0)) begin
            wait_reg <= 2'h0;
            fetch_ack <= 1'b1;
            fetch_data <= fetch_addr ^ 32'h5a5a_a5a5;
        end else begin
            // data is only good in the ack cycle, so scramble it elsewhere
            wait_reg <= fetch_req && !fetch_ack ? wait_reg + 2'h1 : 2'h0;
            fetch_ack <= 1'b0;
            fetch_data <= ~fetch_data;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// randomized self-checking bench for the effective address calculator
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 0, reset_n = 0, ce = 1, start = 0, pc_rel, index_is_addr, index_long, slow;
    logic        bd_present, bd_long, od_present, od_long, ext_we = 0, fetch_ack, fetch_req, done, busy, is_operand;
    logic [3:0]  mode = 0, ext_wsel = 0;
    logic [1:0]  op_size, data_type, index_scale;
    logic [2:0]  data_reg_sel, addr_reg_sel, index_reg_sel;
    logic [7:0]  short_disp_byte;
    logic [15:0] short_disp_word;
    logic [4:0]  bf_width;
    logic [31:0] base_displacement, outer_displacement, abs_addr, imm_data, pc, ext_wdata = 0, fetch_data, fetch_addr;
    logic [31:0] ea_out, bf_mask, regs [16];
    logic [63:0] operand_out;
    int          miscompares = 0, checks_done = 0, cycles = 0;
    eac_core dut (.ref_clk, .reset_n, .ce, .start, .mode, .pc_rel, .op_size, .data_type, .data_reg_sel,
        .addr_reg_sel, .index_reg_sel, .index_is_addr, .index_long, .index_scale, .short_disp_byte,
        .short_disp_word, .base_displacement, .bd_present, .bd_long, .outer_displacement, .od_present,
        .od_long, .abs_addr, .imm_data, .bf_width, .pc, .ext_we, .ext_wsel, .ext_wdata, .fetch_data,
        .fetch_ack, .fetch_req, .fetch_addr, .done, .busy, .is_operand, .ea_out, .operand_out, .bf_mask);
    eac_fetch_mem mem (.ref_clk, .reset_n, .slow, .fetch_req, .fetch_addr, .fetch_data, .fetch_ack);
    always #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] sx16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    function automatic logic [31:0] dsp(input logic [31:0] v, input logic pres, input logic lng);
        return pres ? (lng ? v : sx16(v[15:0])) : 32'h0;
    endfunction
    function automatic logic [31:0] msz(input logic [1:0] s);
        return s == 2'h0 ? 32'hff : s == 2'h1 ? 32'hffff : 32'hffff_ffff;
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic draw();
        {pc_rel, index_is_addr, index_long, bd_present, bd_long, od_present, od_long, slow} = 8'($urandom);
        {op_size, data_type, index_scale, data_reg_sel, addr_reg_sel, index_reg_sel, bf_width} = 20'($urandom);
        {short_disp_byte, short_disp_word} = 24'($urandom);
        base_displacement = $urandom;
        outer_displacement = $urandom;
        abs_addr = $urandom;
        imm_data = $urandom;
        pc = $urandom;
    endtask
    // entered at a negedge; returns at the negedge where done is high so the next start is back to back
    task automatic run_one(input logic [3:0] m);
        logic [31:0] b, x, ix, fa, e, d, st, mk, seen;
        logic [63:0] op;
        draw();
        mode = m;
        if (m != 4'h0) data_type = 2'h0;
        if (m == 4'h1) op_size = 2'h2;
        st = op_size == 2'h0 ? 32'h1 : op_size == 2'h1 ? 32'h2 : 32'h4;
        b = (pc_rel && m >= 4'h5 && m <= 4'h9) ? pc : regs[{1'b1, addr_reg_sel}];
        x = regs[{index_is_addr, index_reg_sel}];
        ix = (index_long ? x : sx16(x[15:0])) << index_scale;
        fa = b + dsp(base_displacement, bd_present, bd_long) + (m == 4'h9 ? ix : 32'h0);
        mk = bf_width == 5'h0 ? 32'hffff_ffff : (32'h1 << bf_width) - 32'h1;
        d = regs[{1'b0, data_reg_sel}];
        op = {32'h0, imm_data & msz(op_size)};
        e = 32'h0;
        case (m)
            4'h0: case (data_type)
                2'h1: op = {32'h0, d & mk};
                2'h2: op = {56'h0, d[11:8], d[3:0]};
                2'h3: op = {48'h0, 4'h0, d[7:4], 4'h0, d[3:0]};
                default: op = op_size == 2'h3 ? {regs[{1'b0, data_reg_sel + 3'h1}], d} : {32'h0, d & msz(op_size)};
            endcase
            4'h1: op = {32'h0, b};
            4'h2, 4'h3: e = b;
            4'h4: e = b - st;
            4'h5: e = b + sx16(short_disp_word);
            4'h6: e = b + {{24{short_disp_byte[7]}}, short_disp_byte} + ix;
            4'h7: e = fa + ix;
            4'h8: e = (fa ^ 32'h5a5a_a5a5) + ix + dsp(outer_displacement, od_present, od_long);
            4'h9: e = (fa ^ 32'h5a5a_a5a5) + dsp(outer_displacement, od_present, od_long);
            4'ha: e = sx16(abs_addr[15:0]);
            4'hb: e = abs_addr;
            default: ;
        endcase
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        check(busy, 1'b1, "busy");
        seen = 32'h0;
        for (int n = 0; n < 12 && done !== 1'b1; n++) begin
            if (fetch_req === 1'b1) seen = fetch_addr;
            // a frozen cycle in the calc step must only delay the result
            ce = !(n == 1 && pc[0]);
            @(negedge ref_clk);
        end
        ce = 1'b1;
        if (m == 4'h8 || m == 4'h9) check(seen, fa, "fetch address");
        check(done, 1'b1, "done");
        check(bf_mask, mk, "mask");
        check(is_operand, m <= 4'h1 || m >= 4'hc, "kind");
        if (m <= 4'h1 || m >= 4'hc) check(operand_out, op, "operand");
        else check(ea_out, e, "address");
        if (m == 4'h3) regs[{1'b1, addr_reg_sel}] = b + st;
        if (m == 4'h4) regs[{1'b1, addr_reg_sel}] = e;
    endtask
    initial begin
        void'($urandom(37));
        draw();
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        check(ea_out, 32'h0, "reset");
        for (int i = 0; i < 16; i++) begin
            regs[i] = i == 9 ? 32'hffff_fffe : $urandom;
            ext_we = 1'b1;
            ext_wsel = 4'(i);
            ext_wdata = regs[i];
            @(negedge ref_clk);
        end
        ext_we = 1'b0;
        $display("register load done");
        for (int m = 0; m < 16; m++) begin
            repeat (20) run_one(4'(m));
            $display("mode %0d done", m);
        end
        summarize();
    end
    // a hang ends the run through the same report
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            summarize();
        end
    end
endmodule
`default_nettype wire
